// [pkg/psm_defs.vh]
// Register map, reset values, fields and timing of the payload signal manager.
// Included by bare name from the design file.
`ifndef PSM_DEFS_VH
`define PSM_DEFS_VH

// Register indices, 16-bit words addressed by a 16-bit pointer
`define PSM_REG_SYS            16'h0000
`define PSM_REG_STATUS         16'h0001
`define PSM_REG_BUSY_MASK      16'h0003
`define PSM_REG_TOKEN_SET      16'h0004
`define PSM_REG_BUSY_FLAGS     16'h0006
`define PSM_REG_CNT_FIRST      16'h0008
`define PSM_REG_CNT_LAST       16'h0017
`define PSM_REG_CTRL           16'h0018
`define PSM_REG_STAT_OUT       16'h0019
`define PSM_REG_LAST_BUSY      16'h001A
`define PSM_REG_SPI_RX         16'h001B
// Pointer high byte of the PLL shadow; bit 7 picks the PLL
`define PSM_SHADOW_PAGE        8'h01

// Reset values and system write mask
`define PSM_SYS_RESET          16'h80CC
`define PSM_SYS_WMASK          16'h82FF
`define PSM_MASK_RESET         16'hFFFF
`define PSM_TOKEN_RESET        16'hFFFF
`define PSM_CTRL_RESET         16'h0001
`define PSM_STAT_OUT_RESET     16'h0000

// System and control register fields
`define PSM_SYS_BYPA           0
`define PSM_SYS_FREQA_LO       2
`define PSM_SYS_BYPB           4
`define PSM_SYS_FREQB_LO       6
`define PSM_CTRL_REGISTERED    0

// Frequency codes
`define PSM_FREQ_UNDEF         2'h0
`define PSM_FREQ_31            2'h1
`define PSM_FREQ_125           2'h2
`define PSM_FREQ_250           2'h3

// Timing
`define PSM_CLK_PERIOD_NS      50
`define PSM_SPI_MIN_PERIOD_NS  100
`define PSM_SPI_HALF_CYC       ((`PSM_SPI_MIN_PERIOD_NS + 2 * `PSM_CLK_PERIOD_NS - 1) / (2 * `PSM_CLK_PERIOD_NS))
`define PSM_SPI_FRAME_BITS     5'h10

`endif

// [hw/psm_top.v]
// Payload signal manager: token ring, trigger/busy OR, busy counters, I2C slave, SPI master.
// Assumes pins synchronous to mclk; I2C lines sampled, not clocked.
//
// Notes on behaviour
// - On a token return, grant passes to the next enabled slot.
// - Token walks enabled slots from the lowest slot index to the highest.
// - Slots not enabled are skipped straight to the next enabled one.
// - Cycle starts on trigger interface token; last finish notifies that board.
// - Enabled slot set changes only through configuration register writes.
// - Trigger outputs of all payloads ORed onto a front-panel output.
// - Buffer-full signals of all payloads ORed toward the trigger interface.
// - Sticky per-slot buffer-full flags; reading the register clears them.
// - Mask bit 1 tracks a slot, 0 excludes it; all tracked after reset.
// - Per-slot 16-bit buffer-full counters at indices 8..23, cleared on read.
// - Slot that last asserted buffer-full is recorded.
// - Status output to payloads, all at once or one at a time.
// - Registered mode resyncs trigger and sync; unregistered passes them through one register stage.
// - Trigger interface board is I2C master; this block is the slave.
// - SPI master programs each PLL according to the requested frequency.
// - Shared SPI data and clock; own select per PLL, only one asserted.
// - SPI clock period never below 100 ns.
// - PLL register reads answered from a local shadow copy.
// - Write: address byte, pointer MSB then LSB, data words MSB first.
// - Pointer auto-increments per data word; stop resets the transfer.
// - Token return input from each payload brings the token back.
`timescale 1ns/100ps
`include "psm_defs.vh"

module psm_top #(
    parameter       SLOTS     = 16,
    parameter [6:0] I2C_ADDR  = 7'h2A,
    parameter [6:0] PLL_DIV_REG = 7'h19,
    parameter [7:0] DIV_31    = 8'h1F,
    parameter [7:0] DIV_125   = 8'h07,
    parameter [7:0] DIV_250   = 8'h03
) (
    input  wire              mclk,
    input  wire              rst_n,
    input  wire              ti_token,
    input  wire [SLOTS-1:0]  token_return,
    output reg  [SLOTS-1:0]  token_grant,
    output reg               token_done,
    input  wire [SLOTS-1:0]  payload_trig,
    input  wire [SLOTS-1:0]  payload_busy,
    output reg               trig_or,
    output reg               busy_or,
    output reg  [SLOTS-1:0]  status_bit,
    input  wire              first_trigger,
    input  wire              second_trigger,
    input  wire              sync_in,
    output reg               first_trigger_fan,
    output reg               second_trigger_fan,
    output reg               sync_fan,
    input  wire              pll_a_unlocked,
    input  wire              pll_a_input_lost,
    input  wire              pll_b_unlocked,
    input  wire              pll_b_input_lost,
    input  wire              regulator_fault,
    output reg               pll_a_mode,
    output reg               pll_b_mode,
    input  wire              scl_in,
    input  wire              sda_in,
    output reg               sda_out,
    output reg               sda_oe,
    output reg               spi_sclk,
    output reg               spi_mosi,
    input  wire              spi_miso,
    output reg  [1:0]        spi_ss_n
);

    localparam T_IDLE  = 1'b0;
    localparam T_GRANT = 1'b1;
    localparam P_ADDR  = 3'h0;
    localparam P_PHI   = 3'h1;
    localparam P_PLO   = 3'h2;
    localparam P_DHI   = 3'h3;
    localparam P_DLO   = 3'h4;
    localparam P_IDLE  = 3'h5;

    // Configuration and status registers
    reg  [15:0] sys_reg;
    reg  [15:0] busy_mask;
    reg  [15:0] token_set;
    reg  [15:0] ctrl_reg;
    reg  [15:0] busy_flags;
    reg  [15:0] busy_cnt [0:SLOTS-1];
    reg  [3:0]  last_busy;
    reg  [15:0] spi_rx;
    reg  [7:0]  shadow [0:255];

    // First enabled slot at or above start
    function [4:0] psm_next;
        input [15:0] en;
        input [4:0]  start;
        integer      i;
        begin
            psm_next = 5'h00;
            for (i = SLOTS - 1; i >= 0; i = i - 1) begin
                if (en[i] && (i >= start))
                    psm_next = {1'b1, i[3:0]};
            end
        end
    endfunction

    // Token ring
    reg              tok_state;
    reg  [3:0]       tok_slot;
    reg              ti_token_q;
    reg  [SLOTS-1:0] ret_q;
    wire [4:0]       first_hop = psm_next(token_set, 5'h00);
    wire [4:0]       next_hop  = psm_next(token_set, {1'b0, tok_slot} + 5'h01);
    wire             ret_rise  = token_return[tok_slot] & ~ret_q[tok_slot];

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tok_state   <= T_IDLE;
            tok_slot    <= 4'h0;
            ti_token_q  <= 1'b0;
            ret_q       <= {SLOTS{1'b0}};
            token_grant <= {SLOTS{1'b0}};
            token_done  <= 1'b0;
        end else begin
            ti_token_q <= ti_token;
            ret_q      <= token_return;
            token_done <= 1'b0;
            case (tok_state)
                T_IDLE: begin
                    if (ti_token & ~ti_token_q) begin
                        if (first_hop[4]) begin
                            tok_slot    <= first_hop[3:0];
                            token_grant <= {{(SLOTS-1){1'b0}}, 1'b1} << first_hop[3:0];
                            tok_state   <= T_GRANT;
                        end else begin
                            token_done <= 1'b1;
                        end
                    end
                end
                T_GRANT: begin
                    if (ret_rise) begin
                        if (next_hop[4]) begin
                            tok_slot    <= next_hop[3:0];
                            token_grant <= {{(SLOTS-1){1'b0}}, 1'b1} << next_hop[3:0];
                        end else begin
                            token_grant <= {SLOTS{1'b0}};
                            token_done  <= 1'b1;
                            tok_state   <= T_IDLE;
                        end
                    end
                end
                default: tok_state <= T_IDLE;
            endcase
        end
    end

    // Aggregation and fanout of trigger and sync
    reg first_trigger_q;
    reg second_trigger_q;
    reg sync_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trig_or            <= 1'b0;
            busy_or            <= 1'b0;
            first_trigger_q            <= 1'b0;
            second_trigger_q            <= 1'b0;
            sync_q             <= 1'b0;
            first_trigger_fan  <= 1'b0;
            second_trigger_fan <= 1'b0;
            sync_fan           <= 1'b0;
            pll_a_mode         <= 1'b0;
            pll_b_mode         <= 1'b0;
        end else begin
            trig_or    <= |payload_trig;
            busy_or    <= |payload_busy;
            first_trigger_q    <= first_trigger;
            second_trigger_q    <= second_trigger;
            sync_q     <= sync_in;
            pll_a_mode <= sys_reg[`PSM_SYS_BYPA];
            pll_b_mode <= sys_reg[`PSM_SYS_BYPB];
            // Registered mode adds a clock of latency
            if (ctrl_reg[`PSM_CTRL_REGISTERED]) begin
                first_trigger_fan  <= first_trigger_q;
                second_trigger_fan <= second_trigger_q;
                sync_fan           <= sync_q;
            end else begin
                first_trigger_fan  <= first_trigger;
                second_trigger_fan <= second_trigger;
                sync_fan           <= sync_in;
            end
        end
    end

    // I2C slave
    reg         scl_q;
    reg         sda_q;
    reg  [2:0]  phase;
    reg  [3:0]  bit_cnt;
    reg  [7:0]  shreg;
    reg         rd_mode;
    reg  [15:0] ptr;
    reg  [7:0]  data_hi;
    reg  [15:0] tx_word;
    reg         tx_lo;
    reg         wr_stb;
    reg  [15:0] wr_data;
    reg         rd_stb;
    reg  [15:0] rd_word;
    wire        scl_rise = scl_in & ~scl_q;
    wire        scl_fall = ~scl_in & scl_q;
    wire        i2c_start = scl_in & scl_q & sda_q & ~sda_in;
    wire        i2c_stop  = scl_in & scl_q & ~sda_q & sda_in;
    wire [15:0] cnt_off   = ptr - `PSM_REG_CNT_FIRST;
    wire        in_cnt    = (ptr >= `PSM_REG_CNT_FIRST) && (ptr <= `PSM_REG_CNT_LAST);
    wire        in_shadow = (ptr[15:8] == `PSM_SHADOW_PAGE);
    wire [7:0]  next_tx   = tx_lo ? tx_word[7:0] : rd_word[15:8];

    always @* begin
        rd_word = 16'h0000;
        if (in_cnt)
            rd_word = busy_cnt[cnt_off[3:0]];
        else if (in_shadow)
            rd_word = {8'h00, shadow[ptr[7:0]]};
        else begin
            case (ptr)
                `PSM_REG_SYS:        rd_word = sys_reg;
                `PSM_REG_STATUS:     rd_word = {4'h0, sys_reg[7:6], sys_reg[3:2], 1'b0, busy_or, trig_or,
                                                regulator_fault, pll_a_unlocked, pll_a_input_lost,
                                                pll_b_unlocked, pll_b_input_lost};
                `PSM_REG_BUSY_MASK:  rd_word = busy_mask;
                `PSM_REG_TOKEN_SET:  rd_word = token_set;
                `PSM_REG_BUSY_FLAGS: rd_word = busy_flags;
                `PSM_REG_CTRL:       rd_word = ctrl_reg;
                `PSM_REG_STAT_OUT:   rd_word = status_bit;
                `PSM_REG_LAST_BUSY:  rd_word = {12'h000, last_busy};
                `PSM_REG_SPI_RX:     rd_word = spi_rx;
                default:             rd_word = 16'h0000;
            endcase
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            phase   <= P_IDLE;
            bit_cnt <= 4'h0;
            shreg   <= 8'h00;
            rd_mode <= 1'b0;
            ptr     <= 16'h0000;
            data_hi <= 8'h00;
            tx_word <= 16'h0000;
            tx_lo   <= 1'b0;
            wr_stb  <= 1'b0;
            wr_data <= 16'h0000;
            rd_stb  <= 1'b0;
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
        end else begin
            scl_q  <= scl_in;
            sda_q  <= sda_in;
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            if (i2c_stop) begin
                phase  <= P_IDLE;
                sda_oe <= 1'b0;
            end else if (i2c_start) begin
                phase   <= P_ADDR;
                bit_cnt <= 4'h0;
                rd_mode <= 1'b0;
                sda_oe  <= 1'b0;
            end else if (phase != P_IDLE) begin
                if (scl_rise) begin
                    if (bit_cnt < 4'h8)
                        shreg <= {shreg[6:0], sda_in};
                    // Master NACK ends our drive
                    if (rd_mode && bit_cnt == 4'h8 && sda_in)
                        phase <= P_IDLE;
                    bit_cnt <= bit_cnt + 4'h1;
                end else if (scl_fall) begin
                    if (rd_mode) begin
                        if (bit_cnt < 4'h8)
                            sda_oe <= ~tx_word[{~tx_lo, 3'h7 - bit_cnt[2:0]}];
                        else if (bit_cnt == 4'h8)
                            sda_oe <= 1'b0;
                        else begin
                            bit_cnt <= 4'h0;
                            tx_lo   <= ~tx_lo;
                            if (!tx_lo) begin
                                sda_oe <= ~tx_word[7];
                                ptr    <= ptr + 16'h0001;
                            end else begin
                                tx_word <= rd_word;
                                rd_stb  <= 1'b1;
                                sda_oe  <= ~rd_word[15];
                            end
                        end
                    end else if (bit_cnt == 4'h8) begin
                        sda_oe <= 1'b1;
                        case (phase)
                            P_ADDR: begin
                                if (shreg[7:1] != I2C_ADDR) begin
                                    sda_oe <= 1'b0;
                                    phase  <= P_IDLE;
                                end else begin
                                    rd_mode <= shreg[0];
                                    tx_lo   <= shreg[0];
                                    phase   <= P_PHI;
                                end
                            end
                            P_PHI: begin
                                ptr[15:8] <= shreg;
                                phase     <= P_PLO;
                            end
                            P_PLO: begin
                                ptr[7:0] <= shreg;
                                phase    <= P_DHI;
                            end
                            P_DHI: begin
                                data_hi <= shreg;
                                phase   <= P_DLO;
                            end
                            P_DLO: begin
                                wr_stb  <= 1'b1;
                                wr_data <= {data_hi, shreg};
                                phase   <= P_DHI;
                            end
                            default: phase <= P_IDLE;
                        endcase
                    end else if (bit_cnt == 4'h9) begin
                        bit_cnt <= 4'h0;
                        sda_oe  <= 1'b0;
                    end
                end
            end
            if (wr_stb)
                ptr <= ptr + 16'h0001;
        end
    end

    // Busy bookkeeping; a new edge in the read cycle survives the clear
    reg  [SLOTS-1:0] busy_q;
    wire [SLOTS-1:0] busy_rise = payload_busy & ~busy_q & busy_mask;
    wire             rd_flags  = rd_stb && (ptr == `PSM_REG_BUSY_FLAGS);
    integer          k;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q     <= {SLOTS{1'b0}};
            busy_flags <= 16'h0000;
            last_busy  <= 4'h0;
            for (k = 0; k < SLOTS; k = k + 1)
                busy_cnt[k] <= 16'h0000;
        end else begin
            busy_q     <= payload_busy;
            busy_flags <= (rd_flags ? 16'h0000 : busy_flags) | busy_rise;
            for (k = 0; k < SLOTS; k = k + 1) begin
                if (busy_rise[k])
                    last_busy <= k[3:0];
                if (rd_stb && in_cnt && cnt_off[3:0] == k[3:0])
                    busy_cnt[k] <= {15'h0000, busy_rise[k]};
                else if (busy_rise[k])
                    busy_cnt[k] <= busy_cnt[k] + 16'h0001;
            end
        end
    end

    // Register writes from the I2C side only
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sys_reg    <= `PSM_SYS_RESET;
            busy_mask  <= `PSM_MASK_RESET;
            token_set  <= `PSM_TOKEN_RESET;
            ctrl_reg   <= `PSM_CTRL_RESET;
            status_bit <= `PSM_STAT_OUT_RESET;
        end else if (wr_stb) begin
            case (ptr)
                `PSM_REG_SYS:       sys_reg    <= wr_data & `PSM_SYS_WMASK;
                `PSM_REG_BUSY_MASK: busy_mask  <= wr_data;
                `PSM_REG_TOKEN_SET: token_set  <= wr_data;
                `PSM_REG_CTRL:      ctrl_reg   <= wr_data;
                `PSM_REG_STAT_OUT:  status_bit <= wr_data;
                default:            ctrl_reg   <= ctrl_reg;
            endcase
        end
    end

    // PLL programming; one pending job, a newer shadow write replaces it
    reg        job_pend;
    reg        job_sel;
    reg [6:0]  job_addr;
    reg [7:0]  job_data;
    reg [1:0]  freq_pend;
    reg        spi_busy;
    reg [15:0] spi_sh;
    reg [4:0]  spi_bits;
    reg [3:0]  spi_div;
    wire       sys_wr   = wr_stb && (ptr == `PSM_REG_SYS);
    wire [1:0] code_a   = sys_reg[`PSM_SYS_FREQA_LO+1:`PSM_SYS_FREQA_LO];
    wire [1:0] code_b   = sys_reg[`PSM_SYS_FREQB_LO+1:`PSM_SYS_FREQB_LO];
    wire [1:0] code_sel = freq_pend[0] ? code_a : code_b;
    reg  [7:0] div_val;

    always @* begin
        case (code_sel)
            `PSM_FREQ_31:  div_val = DIV_31;
            `PSM_FREQ_125: div_val = DIV_125;
            `PSM_FREQ_250: div_val = DIV_250;
            default:       div_val = 8'h00;
        endcase
    end

    always @(posedge mclk) begin
        if (wr_stb && in_shadow)
            shadow[ptr[7:0]] <= wr_data[7:0];
        else if (!spi_busy && !job_pend && freq_pend != 2'h0 && code_sel != `PSM_FREQ_UNDEF)
            shadow[{~freq_pend[0], PLL_DIV_REG}] <= div_val;
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            job_pend  <= 1'b0;
            job_sel   <= 1'b0;
            job_addr  <= 7'h00;
            job_data  <= 8'h00;
            freq_pend <= 2'h0;
            spi_busy  <= 1'b0;
            spi_sh    <= 16'h0000;
            spi_bits  <= 5'h00;
            spi_div   <= 4'h0;
            spi_rx    <= 16'h0000;
            spi_sclk  <= 1'b0;
            spi_mosi  <= 1'b0;
            spi_ss_n  <= 2'h3;
        end else begin
            if (sys_wr)
                freq_pend <= freq_pend | 2'h3;
            if (wr_stb && in_shadow) begin
                job_pend <= 1'b1;
                job_sel  <= ptr[7];
                job_addr <= ptr[6:0];
                job_data <= wr_data[7:0];
            end
            if (!spi_busy) begin
                spi_sclk <= 1'b0;
                if (job_pend || (freq_pend != 2'h0 && code_sel != `PSM_FREQ_UNDEF)) begin
                    spi_busy <= 1'b1;
                    spi_bits <= `PSM_SPI_FRAME_BITS;
                    spi_div  <= 4'h0;
                    if (job_pend) begin
                        if (!(wr_stb && in_shadow))
                            job_pend <= 1'b0;
                        spi_ss_n <= job_sel ? 2'h1 : 2'h2;
                        spi_sh   <= {1'b0, job_addr, job_data};
                        spi_mosi <= 1'b0;
                    end else begin
                        spi_ss_n <= freq_pend[0] ? 2'h2 : 2'h1;
                        spi_sh   <= {1'b0, PLL_DIV_REG, div_val};
                        spi_mosi <= 1'b0;
                        if (!sys_wr)
                            freq_pend <= freq_pend[0] ? {freq_pend[1], 1'b0} : 2'h0;
                    end
                end else if (freq_pend != 2'h0 && !sys_wr) begin
                    // Undefined code: skip this PLL
                    freq_pend <= freq_pend[0] ? {freq_pend[1], 1'b0} : 2'h0;
                end
            end else if (spi_div == `PSM_SPI_HALF_CYC - 1) begin
                spi_div <= 4'h0;
                if (!spi_sclk) begin
                    spi_sclk <= 1'b1;
                    spi_rx   <= {spi_rx[14:0], spi_miso};
                    spi_bits <= spi_bits - 5'h01;
                end else begin
                    spi_sclk <= 1'b0;
                    if (spi_bits == 5'h00) begin
                        spi_busy <= 1'b0;
                        spi_ss_n <= 2'h3;
                    end else begin
                        spi_sh   <= {spi_sh[14:0], 1'b0};
                        spi_mosi <= spi_sh[14];
                    end
                end
            end else
                spi_div <= spi_div + 4'h1;
        end
    end

endmodule // psm_top

// [testbench/psm_props_properties.sv]
// Pin checker for psm_top: token ring, SPI select and clock.
// Bound from tb; single mclk domain.
`timescale 1ns/100ps
module psm_props #(parameter SLOTS = 16) (
    input wire             mclk,
    input wire             rst_n,
    input wire             ti_token,
    input wire [SLOTS-1:0] token_return,
    input wire [SLOTS-1:0] token_grant,
    input wire             token_done,
    input wire             spi_sclk,
    input wire [1:0]       spi_ss_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_one_grant: assert property ($onehot0(token_grant)) else $error("grant");
    a_grant_held: assert property (token_grant != 0 && (token_grant & token_return) == 0
        |=> $stable(token_grant)) else $error("hold");
    a_grant_fwd: assert property (|(token_grant & token_return & ~$past(token_return))
        |=> (token_done ? token_grant == 0 : token_grant > $past(token_grant))) else $error("fwd");
    a_ring_start: assert property ($rose(ti_token) && token_grant == 0 && !token_done
        |=> token_grant != 0 || token_done) else $error("start");
    a_grant_cause: assert property (token_grant != 0 && $past(token_grant) == 0
        |-> $past(ti_token) && !$past(ti_token, 2)) else $error("cause");
    a_done_pulse: assert property (token_done |=> !token_done) else $error("done");
    a_one_select: assert property (spi_ss_n != 2'b00) else $error("select");
    a_sclk_framed: assert property (spi_sclk |-> !(&spi_ss_n)) else $error("framed");
    a_sclk_rate: assert property (spi_sclk |=> !spi_sclk) else $error("rate");
    cover property (token_done);
    cover property (!spi_ss_n[0]);
    cover property (!spi_ss_n[1]);
endmodule // psm_props

// [testbench/psm_far_model.sv]
// Payload and PLL stand-in: hands the token back lag + 2 cycles after the grant.
// Assumes mclk shared with the design.
`timescale 1ns/100ps
module psm_far_model (
    input  wire        mclk,
    input  wire [3:0]  lag,
    input  wire [15:0] token_grant,
    output reg  [15:0] token_return = 16'h0000,
    input  wire [1:0]  spi_ss_n,
    output wire        spi_miso
);
    reg [15:0] held = 16'h0000;
    reg [3:0]  age = 4'h0;
    // Idle MISO toggles so no stale bit is ever read
    assign spi_miso = (&spi_ss_n) ? ~mclk : 1'b0;
    always @(posedge mclk) begin
        held <= token_grant;
        age <= (token_grant != held) ? 4'h0 : age + 4'h1;
        token_return <= (token_grant == held && age >= lag) ? token_grant : 16'h0000;
    end
endmodule // psm_far_model

// [testbench/tb.sv]
// Bench for psm_top: I2C master tasks, token, busy, fan and SPI checks.
// Assumes psm_top defaults and a 20 MHz mclk.
`timescale 1ns/100ps
module tb;
    reg         mclk = 1'b0;
    reg         rst_n = 1'b0;
    reg         ti_token = 1'b0;
    reg [15:0]  payload_trig = 16'h0000;
    reg [15:0]  payload_busy = 16'h0000;
    reg         tg = 1'b0;
    reg         scl = 1'b1;
    reg         sdm = 1'b1;
    reg [3:0]   lag = 4'h3;
    reg [4:0]   flt = 5'h00;
    reg [15:0]  seen = 16'h0000;
    reg [15:0]  sh;
    reg [15:0]  r;
    integer     err_count = 0;
    integer     checks = 0;
    integer     n;
    wire [15:0] token_return, token_grant, status_bit;
    wire        token_done, trig_or, busy_or, first_trigger_fan, second_trigger_fan, sync_fan;
    wire        pll_a_mode, pll_b_mode, sda_oe, spi_sclk, spi_mosi, spi_miso;
    wire [1:0]  spi_ss_n;
    wire        sda = sdm & ~sda_oe;
    psm_top psm_top_inst (.mclk, .rst_n, .ti_token, .token_return, .token_grant, .token_done, .payload_trig,
        .payload_busy, .trig_or, .busy_or, .status_bit, .first_trigger(tg), .second_trigger(tg), .sync_in(tg),
        .first_trigger_fan, .second_trigger_fan, .sync_fan, .pll_a_unlocked(flt[0]), .pll_a_input_lost(flt[1]),
        .pll_b_unlocked(flt[2]), .pll_b_input_lost(flt[3]), .regulator_fault(flt[4]), .pll_a_mode,
        .pll_b_mode, .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe, .spi_sclk, .spi_mosi, .spi_miso, .spi_ss_n);
    psm_far_model psm_far_model_inst (.mclk, .lag, .token_grant, .token_return, .spi_ss_n, .spi_miso);
    initial forever #25 mclk = ~mclk;
    always @(posedge mclk) seen <= seen | token_grant;
    always @(posedge spi_sclk) if (!spi_ss_n[0]) sh <= {sh[14:0], spi_mosi};
    task ck(input string nm, input [15:0] e, input [15:0] s);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task close_out;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task wt;
        if (n >= 300) begin
            err_count++;
            close_out;
        end
    endtask
    // Each hb step holds SDA and SCL for 4 mclk, above the 3 the slave needs
    task hb(input s, input c);
        sdm = s;
        scl = c;
        repeat (4) @(negedge mclk);
    endtask
    task cond(input [3:0] sv, input [3:0] cv);
        for (int i = 3; i >= 0; i--) hb(sv[i], cv[i]);
    endtask
    task xb(input [8:0] d, output [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            hb(d[i], 0);
            hb(d[i], 1);
            q[i] = sda;
            hb(d[i], 0);
        end
    endtask
    task acc(input rd, input [15:0] a, input [15:0] w);
        reg [8:0] q, h;
        cond(4'b1100, 4'b0110);
        xb(9'h0A9, q);
        ck("ack", 16'h0000, {15'h0000, q[0]});
        xb({a[15:8], 1'b1}, q);
        xb({a[7:0], 1'b1}, q);
        if (rd) begin
            cond(4'b1100, 4'b0110);
            xb(9'h0AB, q);
            xb(9'h1FE, h);
            xb(9'h1FF, q);
            r = {h[8:1], q[8:1]};
        end else begin
            xb({w[15:8], 1'b1}, q);
            xb({w[7:0], 1'b1}, q);
        end
        cond(4'b0011, 4'b0111);
    endtask
    task rc(input string nm, input [15:0] a, input [15:0] e);
        acc(1'b1, a, 16'h0000);
        ck(nm, e, r);
    endtask
    initial begin
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        rc("mask", 16'h0003, 16'hFFFF);
        rc("unmapped", 16'h00F0, 16'h0000);
        acc(1'b0, 16'h0004, 16'h0005);
        ti_token = 1'b1;
        for (n = 0; n < 300 && !token_done; n++) @(negedge mclk);
        wt;
        ck("granted", 16'h0005, seen);
        acc(1'b0, 16'h0003, 16'h0008);
        for (n = 0; n < 2; n++) begin
            payload_busy = 16'h0018;
            payload_trig = 16'h8000;
            repeat (2) @(negedge mclk);
            ck("or", 16'h0003, {trig_or, busy_or});
            payload_busy = 16'h0000;
            repeat (2) @(negedge mclk);
        end
        rc("flags", 16'h0006, 16'h0008);
        rc("flags clr", 16'h0006, 16'h0000);
        rc("count", 16'h000B, 16'h0002);
        rc("count clr", 16'h000B, 16'h0000);
        rc("last", 16'h001A, 16'h0003);
        acc(1'b0, 16'h0019, 16'hA5A5);
        ck("status", 16'hA5A5, status_bit);
        for (n = 1; n >= 0; n--) begin
            acc(1'b0, 16'h0018, n[15:0]);
            tg = 1'b1;
            @(negedge mclk);
            ck("fan 1", n ? 16'h0000 : 16'h0007, {first_trigger_fan, second_trigger_fan, sync_fan});
            @(negedge mclk);
            ck("fan 2", 16'h0007, {first_trigger_fan, second_trigger_fan, sync_fan});
            tg = 1'b0;
            repeat (3) @(negedge mclk);
        end
        acc(1'b0, 16'h0000, 16'h80CD);
        for (n = 0; n < 300 && spi_ss_n[0]; n++) @(negedge mclk);
        wt;
        for (n = 0; n < 300 && !spi_ss_n[0]; n++) @(negedge mclk);
        wt;
        ck("frame", 16'h1903, sh);
        ck("mode", 16'h0002, {14'h0000, pll_a_mode, pll_b_mode});
        close_out;
    end
endmodule // tb
bind psm_top psm_props #(.SLOTS(SLOTS)) psm_props_inst (.mclk, .rst_n, .ti_token, .token_return, .token_grant,
    .token_done, .spi_sclk, .spi_ss_n);
